// ### hdl/wake_filter_pkg.sv
// Constants for the selective-wake identifier filter registers.
package wake_filter_pkg;
  localparam logic [6:0]  ADDR_IDENT_LOW  = 7'h33;
  localparam logic [6:0]  ADDR_MASK_HIGH  = 7'h34;
  localparam logic [15:0] IDENT_LOW_RESET = 16'h0000;
  localparam logic [15:0] MASK_HIGH_RESET = 16'h0000;
  localparam logic [15:0] IDENT_LOW_WMASK = 16'hFF7F;
  localparam int          RTR_BIT         = 1;
  localparam int          IDE_BIT         = 0;
  localparam int          RESERVED_BIT    = 7;
  localparam int          IDENT_LO_MSB    = 12;
  localparam int          IDENT_HI_LSB    = 13;
endpackage

// ### hdl/can_wake_frame_id_filter_regs.sv
// Selective-wake identifier and high compare-mask registers with match logic.
`timescale 1ns/1ps
`default_nettype none
module can_wake_frame_id_filter_regs
  import wake_filter_pkg::*;
(
  // Clock and resets.
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        soft_reset,
  input  wire logic        restart,
  // Register port.
  input  wire logic        reg_write,
  input  wire logic [6:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  // Config-valid flag handling.
  input  wire logic        config_valid_set,
  input  wire logic        wake_up_event,
  input  wire logic        other_config_write,
  output logic             wake_config_valid,
  // Received frame to match, low compare enables and high identifier bits.
  input  wire logic        frame_valid,
  input  wire logic [28:0] frame_ident,
  input  wire logic        frame_remote,
  input  wire logic        frame_extended,
  input  wire logic [12:0] compare_enable_low,
  input  wire logic [15:0] ident_high,
  output logic             wake_up_frame_match
);

  typedef struct packed {
    logic [15:0] ident_low;
    logic [15:0] mask_high;
    logic        cfg_valid;
    logic        match;
  } state_t;

  state_t st;
  state_t next_st;

  // Low identifier bits 12..0 regathered from the split register layout.
  function automatic logic [12:0] ident_low_bits(input logic [15:0] r);
    ident_low_bits = {r[15:8], r[6:2]};
  endfunction

  logic [28:0] stored_ident;
  logic [28:0] enables;
  logic        write_low;
  logic        write_high;
  logic        id_equal;

  always_comb
  begin
    write_low    = reg_write && (reg_addr == ADDR_IDENT_LOW);
    write_high   = reg_write && (reg_addr == ADDR_MASK_HIGH);
    stored_ident = {ident_high, ident_low_bits(st.ident_low)};
    enables      = {st.mask_high, compare_enable_low};
    // Only enabled positions take part in the compare.
    id_equal     = (((frame_ident ^ stored_ident) & enables) == 29'h0);
    next_st      = st;
    if (write_low)
    begin
      next_st.ident_low = reg_wdata & IDENT_LOW_WMASK;
    end
    if (write_high)
    begin
      next_st.mask_high = reg_wdata;
    end
    if (restart)
    begin
      // Restart scrubs the reserved bit and drops a same-cycle register write; stored settings survive.
      next_st.ident_low = st.ident_low & IDENT_LOW_WMASK;
      next_st.mask_high = st.mask_high;
    end
    if (config_valid_set)
    begin
      next_st.cfg_valid = 1'b1;
    end
    // A clear cause beats a simultaneous set so stale configs never arm.
    if (wake_up_event || write_low || write_high || other_config_write || soft_reset)
    begin
      next_st.cfg_valid = 1'b0;
    end
    next_st.match = frame_valid && st.cfg_valid && id_equal
                    && (frame_remote == st.ident_low[RTR_BIT])
                    && (frame_extended == st.ident_low[IDE_BIT]);
    if (soft_reset)
    begin
      next_st.ident_low = IDENT_LOW_RESET;
      next_st.mask_high = MASK_HIGH_RESET;
      next_st.match     = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  always_comb
  begin
    case (reg_addr)
      ADDR_IDENT_LOW: reg_rdata = st.ident_low & IDENT_LOW_WMASK;
      ADDR_MASK_HIGH: reg_rdata = st.mask_high;
      default:        reg_rdata = 16'h0000;
    endcase
  end

  assign wake_config_valid   = st.cfg_valid;
  assign wake_up_frame_match = st.match;

  // Storage and read-back of the low identifier register.
  chk_reserved_zero: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    st.ident_low[RESERVED_BIT] == 1'b0)
    else $error("reserved bit set");

  chk_reserved_reads_zero: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    reg_addr == ADDR_IDENT_LOW |-> reg_rdata[RESERVED_BIT] == 1'b0)
    else $error("reserved bit read as one");

  chk_low_write_lands: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    write_low && !restart && !soft_reset |=> st.ident_low == ($past(reg_wdata) & IDENT_LOW_WMASK))
    else $error("low write lost");

  chk_ident_field_write: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    write_low && !restart && !soft_reset |=> ident_low_bits(st.ident_low) == ident_low_bits($past(reg_wdata)))
    else $error("identifier field misplaced");

  chk_type_flag_write: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    write_low && !restart && !soft_reset |=> st.ident_low[RTR_BIT] == $past(reg_wdata[RTR_BIT]))
    else $error("frame type flag lost");

  chk_format_flag_write: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    write_low && !restart && !soft_reset |=> st.ident_low[IDE_BIT] == $past(reg_wdata[IDE_BIT]))
    else $error("format flag lost");

  chk_low_read_path: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    reg_addr == ADDR_IDENT_LOW |-> reg_rdata == st.ident_low)
    else $error("low register read wrong");

  chk_low_hold: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !write_low && !restart && !soft_reset |=> $stable(st.ident_low))
    else $error("low register changed without write");

  // Storage and read-back of the high compare mask, and zero reads from unmapped addresses.
  chk_high_write_lands: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    write_high && !restart && !soft_reset |=> st.mask_high == $past(reg_wdata))
    else $error("high write lost");

  chk_high_read_path: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    reg_addr == ADDR_MASK_HIGH |-> reg_rdata == st.mask_high)
    else $error("high mask read wrong");

  chk_high_hold: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !write_high && !soft_reset |=> $stable(st.mask_high))
    else $error("high mask changed without write");

  chk_unmapped_read: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    reg_addr != ADDR_IDENT_LOW && reg_addr != ADDR_MASK_HIGH |-> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");

  // Soft reset and restart.
  chk_soft_reset_clears: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    soft_reset |=> st.ident_low == IDENT_LOW_RESET && st.mask_high == MASK_HIGH_RESET)
    else $error("soft reset not cleared");

  chk_soft_reset_cfg: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    soft_reset |=> !wake_config_valid)
    else $error("soft reset left config valid");

  chk_soft_reset_match: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    soft_reset |=> !wake_up_frame_match)
    else $error("soft reset left a match");

  chk_restart_keeps_mask: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    restart && !soft_reset |=> $stable(st.mask_high))
    else $error("mask changed by restart");

  chk_restart_keeps_id: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    restart && !soft_reset |=> st.ident_low == ($past(st.ident_low) & IDENT_LOW_WMASK))
    else $error("ident changed by restart");

  chk_restart_flags: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    restart && !soft_reset |=> st.ident_low[RTR_BIT] == $past(st.ident_low[RTR_BIT])
      && st.ident_low[IDE_BIT] == $past(st.ident_low[IDE_BIT]))
    else $error("flags changed by restart");

  // Config-valid flag.
  chk_cfg_clear: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (wake_up_event || write_low || write_high) |=> !wake_config_valid)
    else $error("config valid not cleared");

  chk_other_write_clears: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    other_config_write |=> !wake_config_valid)
    else $error("other config write kept valid");

  chk_clear_beats_set: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    config_valid_set && wake_up_event |=> !wake_config_valid)
    else $error("set won over wake clear");

  chk_cfg_set: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    config_valid_set && !wake_up_event && !write_low && !write_high && !other_config_write
      && !soft_reset |=> wake_config_valid)
    else $error("config valid not set");

  chk_cfg_hold: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !config_valid_set && !wake_up_event && !write_low && !write_high && !other_config_write
      && !soft_reset |=> $stable(wake_config_valid))
    else $error("config valid changed by itself");

  // Frame matching.
  chk_match_gated: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    wake_up_frame_match |-> $past(st.cfg_valid) && $past(frame_valid))
    else $error("match without valid config");

  chk_no_match_unarmed: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !st.cfg_valid |=> !wake_up_frame_match)
    else $error("match while not armed");

  chk_match_pulse: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !frame_valid |=> !wake_up_frame_match)
    else $error("match without frame");

  chk_type_mismatch: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    frame_valid && (frame_remote != st.ident_low[RTR_BIT]) |=> !wake_up_frame_match)
    else $error("frame type ignored");

  chk_format_mismatch: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    frame_valid && (frame_extended != st.ident_low[IDE_BIT]) |=> !wake_up_frame_match)
    else $error("format ignored");

  chk_masked_bit: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    frame_valid && !id_equal |=> !wake_up_frame_match)
    else $error("enabled bit mismatch matched");

  chk_disabled_ignored: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    frame_valid && st.cfg_valid && !soft_reset && id_equal
      && (((frame_ident ^ stored_ident) & ~enables) != 29'h0)
      && (frame_remote == st.ident_low[RTR_BIT]) && (frame_extended == st.ident_low[IDE_BIT])
      |=> wake_up_frame_match)
    else $error("disabled bit blocked a match");

  chk_match_complete: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    frame_valid && st.cfg_valid && !soft_reset && id_equal
      && (frame_remote == st.ident_low[RTR_BIT]) && (frame_extended == st.ident_low[IDE_BIT])
      |=> wake_up_frame_match)
    else $error("full match not reported");

  // Main scenarios worth seeing at least once.
  cov_match: cover property (
    @(posedge core_clk) disable iff (!rst_n)
    wake_up_frame_match);

  cov_restart: cover property (
    @(posedge core_clk) disable iff (!rst_n)
    restart && st.mask_high != MASK_HIGH_RESET);

  cov_cfg_armed: cover property (
    @(posedge core_clk) disable iff (!rst_n)
    config_valid_set ##1 wake_config_valid);

  cov_soft_reset_clear: cover property (
    @(posedge core_clk) disable iff (!rst_n)
    soft_reset && st.mask_high != MASK_HIGH_RESET);

  cov_ignored_bit_match: cover property (
    @(posedge core_clk) disable iff (!rst_n)
    frame_valid && st.cfg_valid && id_equal && (((frame_ident ^ stored_ident) & ~enables) != 29'h0));

endmodule
`default_nettype wire

// ### verif/wake_host_model.sv
// Host model that drives the register port of the filter.
`timescale 1ns/1ps
`default_nettype none
module wake_host_model
(
  // Request from the bench.
  input  wire logic        go,
  input  wire logic [6:0]  addr,
  input  wire logic [15:0] data,
  // Register port.
  output logic             reg_write,
  output logic [6:0]       reg_addr,
  output logic [15:0]      reg_wdata
);
  // Idle data is inverted so a stale word never passes for a real write.
  assign reg_write = go;
  assign reg_addr  = addr;
  assign reg_wdata = go ? data : ~data;
endmodule
`default_nettype wire

// ### verif/tb.sv
// Self-checking bench for the wake filter registers.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import wake_filter_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst_n    = 1'b0;
  logic        go       = 1'b0;
  logic [6:0]  addr     = 7'h00;
  logic [15:0] data     = 16'h0000;
  logic [4:0]  ctl      = 5'h00;
  logic        fv       = 1'b0;
  logic [28:0] fid      = 29'h0;
  logic [1:0]  ft       = 2'h0;
  logic [12:0] cel      = 13'h1FFF;
  logic [15:0] ihi      = 16'h0000;
  logic        wr_s, valid, match;
  logic [6:0]  wa;
  logic [15:0] wd, rdata;
  int          miscompares = 0;
  int          cmp_count   = 0;
  int          cyc         = 0;
  always #25 core_clk = ~core_clk;
  wake_host_model host_u (.go(go), .addr(addr), .data(data), .reg_write(wr_s),
    .reg_addr(wa), .reg_wdata(wd));
  can_wake_frame_id_filter_regs dut_u (.core_clk(core_clk), .rst_n(rst_n),
    .soft_reset(ctl[4]), .restart(ctl[3]), .reg_write(wr_s), .reg_addr(wa),
    .reg_wdata(wd), .reg_rdata(rdata), .config_valid_set(ctl[2]),
    .wake_up_event(ctl[1]), .other_config_write(ctl[0]), .wake_config_valid(valid),
    .frame_valid(fv), .frame_ident(fid), .frame_remote(ft[1]), .frame_extended(ft[0]),
    .compare_enable_low(cel), .ident_high(ihi), .wake_up_frame_match(match));
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic step();
    @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    step();
    go = 1'b1;
    addr = a;
    data = d;
    step();
    go = 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    addr = a;
    #1;
    chk("rdata", rdata, e);
  endtask
  task automatic pl(input logic [4:0] v);
    step();
    ctl = v;
    step();
    ctl = 5'h00;
  endtask
  task automatic fr(input logic [28:0] id, input logic [1:0] t, input logic e);
    step();
    fv = 1'b1;
    fid = id;
    ft = t;
    step();
    fv = 1'b0;
    chk("match", {15'h0, match}, {15'h0, e});
  endtask
  task automatic t_regs();
    rd(ADDR_IDENT_LOW, 16'h0000);
    wr(ADDR_IDENT_LOW, 16'hFFFF);
    rd(ADDR_IDENT_LOW, 16'hFF7F);
    wr(ADDR_MASK_HIGH, 16'hA5C3);
    rd(ADDR_MASK_HIGH, 16'hA5C3);
    pl(5'h08);
    rd(ADDR_IDENT_LOW, 16'hFF7F);
    rd(ADDR_MASK_HIGH, 16'hA5C3);
  endtask
  task automatic t_match();
    wr(ADDR_IDENT_LOW, 16'h0A57);
    wr(ADDR_MASK_HIGH, 16'hFFFF);
    pl(5'h04);
    chk("valid", {15'h0, valid}, 16'h0001);
    fr(29'h0000_0155, 2'b11, 1'b1);
    fr(29'h0010_0155, 2'b11, 1'b0);
    fr(29'h0000_0155, 2'b01, 1'b0);
    fr(29'h0000_0155, 2'b10, 1'b0);
    wr(ADDR_MASK_HIGH, 16'hFF7F);
    chk("valid", {15'h0, valid}, 16'h0000);
    pl(5'h04);
    fr(29'h0010_0155, 2'b11, 1'b1);
    pl(5'h02);
    fr(29'h0000_0155, 2'b11, 1'b0);
    pl(5'h04);
    pl(5'h01);
    chk("valid", {15'h0, valid}, 16'h0000);
    pl(5'h10);
    rd(ADDR_IDENT_LOW, IDENT_LOW_RESET);
    rd(ADDR_MASK_HIGH, MASK_HIGH_RESET);
  endtask
  task automatic t_low();
    wr(ADDR_MASK_HIGH, 16'hFFFF);
    ihi = 16'h0001;
    cel = 13'h1FFE;
    pl(5'h04);
    fr(29'h0000_2001, 2'b00, 1'b1);
    fr(29'h0000_0000, 2'b00, 1'b0);
    fr(29'h0000_2000, 2'b01, 1'b0);
  endtask
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      miscompares++;
      summarize();
    end
  end
  initial
  begin
    repeat (5) @(posedge core_clk);
    #1 rst_n = 1'b1;
    t_regs();
    t_match();
    t_low();
    summarize();
  end
endmodule
`default_nettype wire
